// File: core/hrs_map.svh
// Purpose: Timing counts and reset values for the hub reset/attach sequencer
// Assumes: 250 MHz core clock, 4 ns period
// Notes:   Times are kept in their own unit; cycle counts derive from them
`ifndef HRS_MAP_SVH
`define HRS_MAP_SVH
// ==========================================================
// Clock
// ==========================================================
`define HRS_CLK_MHZ            250
// ==========================================================
// Times in their own unit
// ==========================================================
`define HRS_RECOVER_US         500
`define HRS_EEPROM_READ_MS     40
`define HRS_ATTACH_MS          40
`define HRS_SMB_ATTACH_MS      0
// ==========================================================
// Cycle counts (exact products; a zero time becomes one cycle)
// ==========================================================
`define HRS_RECOVER_CYC        (`HRS_RECOVER_US * `HRS_CLK_MHZ)
`define HRS_EEPROM_READ_CYC    (`HRS_EEPROM_READ_MS * 1000 * `HRS_CLK_MHZ)
`define HRS_ATTACH_CYC         (`HRS_ATTACH_MS * 1000 * `HRS_CLK_MHZ)
`define HRS_SMB_ATTACH_CYC     1
// ==========================================================
// Widths and reset values
// ==========================================================
`define HRS_NPORTS             4
`define HRS_ADDR_W             7
`define HRS_ADDR_RST           7'h00
`define HRS_CNT_W              24
`endif

// File: core/hrs_pkg.sv
// Purpose: Types shared by the sequencer files
// Assumes: No map header included; the state width is fixed at 3 bits
// Notes:   States carry no explicit codes
`default_nettype none
package hrs_pkg;
  // Sequencer states
  typedef enum logic [2:0]
  {
    HRS_RECOVER,
    HRS_EE_READ,
    HRS_EE_WAIT,
    HRS_SMB_LOAD,
    HRS_SMB_WAIT,
    HRS_ATTACHED
  } hrs_state_t;
endpackage : hrs_pkg
`default_nettype wire

// File: core/hrs_sequencer.sv
// Purpose: Reset, configuration and attach sequencing for a hub controller
// Assumes: Bus reset, suspend, load-done and strap come from outside the clock domain
// Notes:   Core runs on one 250 MHz clock; long waits use the shared down timer
// How it works
// - Bus reset zeroes address, clears configuration
// - Bus reset drops port power unless charging
// - Bus reset flushes every translator buffer
// - Bus reset wakes a suspended hub
// - Upstream reset never reaches downstream ports
// - Smbus mode attaches immediately after load
// - Eeprom mode attaches 40 ms after read
// - Operational two cycles after the 500 us recovery wait ends
// - Smbus mode waits forever for load
// - Hardware reset returns everything to defaults
`include "hrs_map.svh"
`default_nettype none
module hrs_sequencer
  import hrs_pkg::*;
#(
  parameter int RECOVER_CYC = `HRS_RECOVER_CYC,     // Recovery wait, shortened in simulation
  parameter int EEREAD_CYC  = `HRS_EEPROM_READ_CYC, // Configuration read time
  parameter int ATTACH_CYC  = `HRS_ATTACH_CYC       // Eeprom-mode attach delay
)
(
  input  wire logic                    CLK_IN,
  input  wire logic                    RST_IN,
  input  wire logic                    SMB_MODE_IN,           // Strap: 1 selects SMBus code load
  input  wire logic                    LOAD_DONE_IN,          // Code load finished (level)
  input  wire logic                    BUS_RESET_IN,          // Upstream bus reset seen (level)
  input  wire logic                    SUSPEND_REQ_IN,        // Upstream idle asks for suspend
  input  wire logic                    SET_CONFIG_IN,         // Host configures hub (pulse, same domain)
  input  wire logic [`HRS_ADDR_W-1:0]  SET_ADDR_IN,           // Address from enumeration
  input  wire logic                    SET_ADDR_VALID_IN,     // Address strobe (same domain)
  input  wire logic [`HRS_NPORTS-1:0]  PORT_ON_REQ_IN,        // Port power asked by hub logic
  input  wire logic [`HRS_NPORTS-1:0]  CHARGE_PORT_ENABLE_IN, // Charging ports keep power
  output var  logic                    OPERATIONAL_OUT,       // Recovery over
  output var  logic                    CFG_READ_OUT,          // Eeprom read in progress
  output var  logic                    ATTACH_OUT,            // Pull-up on upstream port
  output var  logic [`HRS_ADDR_W-1:0]  DEV_ADDR_OUT,          // Current device address
  output var  logic                    CONFIGURED_OUT,        // Configured state
  output var  logic [`HRS_NPORTS-1:0]  PORT_POWER_ENABLE_OUT, // Downstream power enables
  output var  logic                    TT_FLUSH_OUT,          // Translator buffer flush (level)
  output var  logic                    SUSPENDED_OUT,         // Suspended state
  output var  logic                    DS_RESET_OUT           // Downstream reset signalling
);
  // ==========================================================
  // Input synchronisers
  // ==========================================================
  logic [3:0] meta_q;   // First stage, read only by the second
  logic [3:0] sync_q;   // Second stage
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
    end
    else
    begin
      meta_q <= {SMB_MODE_IN, LOAD_DONE_IN, BUS_RESET_IN, SUSPEND_REQ_IN};
      sync_q <= meta_q;
    end
  end
  logic smb_mode_s;     // Synchronised strap
  logic load_done_s;    // Synchronised load completion
  logic bus_reset_s;    // Synchronised bus reset
  logic suspend_s;      // Synchronised suspend request
  assign {smb_mode_s, load_done_s, bus_reset_s, suspend_s} = sync_q;

  // ==========================================================
  // Sequencer
  // ==========================================================
  hrs_state_t              state_q;    // Current step
  logic                    tmr_load;   // Load the timer this cycle
  logic [`HRS_CNT_W-1:0]   tmr_val;    // Value to load
  logic                    tmr_done;   // Timer expired
  logic                    started_q;  // Timer armed for first step
  logic                    mode_q;     // Mode caught after release

  hrs_timer u_timer
  (
    .clk_in   (CLK_IN),
    .rst_in   (RST_IN),
    .load_in  (tmr_load),
    .value_in (tmr_val),
    .done_out (tmr_done)
  );

  // Timer load choice per step
  always_comb
  begin
    tmr_load = 1'b0;
    tmr_val  = `HRS_CNT_W'(RECOVER_CYC);
    if (!started_q)
      tmr_load = 1'b1;
    else if (state_q == HRS_RECOVER && tmr_done && !mode_q)
    begin
      tmr_load = 1'b1;
      tmr_val  = `HRS_CNT_W'(EEREAD_CYC);
    end
    else if (state_q == HRS_EE_READ && tmr_done)
    begin
      tmr_load = 1'b1;
      tmr_val  = `HRS_CNT_W'(ATTACH_CYC);
    end
    else if (state_q == HRS_SMB_LOAD && load_done_s)
    begin
      tmr_load = 1'b1;
      tmr_val  = `HRS_CNT_W'(`HRS_SMB_ATTACH_CYC);
    end
  end

  // Step through recovery, configuration and attach
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      state_q   <= HRS_RECOVER;
      started_q <= 1'b0;
      mode_q    <= 1'b0;
    end
    else
    begin
      started_q <= 1'b1;
      // Catch the strap while recovery runs
      if (state_q == HRS_RECOVER)
        mode_q <= smb_mode_s;
      unique case (state_q)
        HRS_RECOVER:
          // Only begin configuration once recovery ends
          if (started_q && tmr_done)
            state_q <= mode_q ? HRS_SMB_LOAD : HRS_EE_READ;
        HRS_EE_READ:
          if (tmr_done)
            state_q <= HRS_EE_WAIT;
        HRS_EE_WAIT:
          if (!tmr_load && tmr_done)
            state_q <= HRS_ATTACHED;
        HRS_SMB_LOAD:
          // No timeout: hold until load completes
          if (load_done_s)
            state_q <= HRS_SMB_WAIT;
        HRS_SMB_WAIT:
          if (!tmr_load && tmr_done)
            state_q <= HRS_ATTACHED;
        HRS_ATTACHED:
          state_q <= HRS_ATTACHED;
      endcase
    end
  end

  // ==========================================================
  // Sequencer outputs
  // ==========================================================
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      OPERATIONAL_OUT <= 1'b0;
      CFG_READ_OUT    <= 1'b0;
      ATTACH_OUT      <= 1'b0;
    end
    else
    begin
      OPERATIONAL_OUT <= (state_q != HRS_RECOVER);
      CFG_READ_OUT    <= (state_q == HRS_EE_READ);
      ATTACH_OUT      <= (state_q == HRS_ATTACHED);
    end
  end

  // ==========================================================
  // Device state and bus reset response
  // ==========================================================
  // Address and configuration; bus reset wins over any host write
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      DEV_ADDR_OUT   <= `HRS_ADDR_RST;
      CONFIGURED_OUT <= 1'b0;
    end
    else if (bus_reset_s)
    begin
      DEV_ADDR_OUT   <= `HRS_ADDR_RST;
      CONFIGURED_OUT <= 1'b0;
    end
    else
    begin
      if (SET_ADDR_VALID_IN && ATTACH_OUT)
        DEV_ADDR_OUT <= SET_ADDR_IN;
      if (SET_CONFIG_IN && ATTACH_OUT)
        CONFIGURED_OUT <= 1'b1;
    end
  end

  // Port power: charging ports keep power through bus reset
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      PORT_POWER_ENABLE_OUT <= '0;
    else if (bus_reset_s)
      PORT_POWER_ENABLE_OUT <= PORT_POWER_ENABLE_OUT & CHARGE_PORT_ENABLE_IN;
    else
      PORT_POWER_ENABLE_OUT <= PORT_ON_REQ_IN & {`HRS_NPORTS{CONFIGURED_OUT}};
  end

  // Flush, wake and downstream reset
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      TT_FLUSH_OUT  <= 1'b1;
      SUSPENDED_OUT <= 1'b0;
      DS_RESET_OUT  <= 1'b0;
    end
    else
    begin
      TT_FLUSH_OUT  <= bus_reset_s || !ATTACH_OUT;
      // Bus reset overrides a suspend request
      if (bus_reset_s)
        SUSPENDED_OUT <= 1'b0;
      else if (suspend_s && ATTACH_OUT)
        SUSPENDED_OUT <= 1'b1;
      else if (!suspend_s)
        SUSPENDED_OUT <= 1'b0;
      DS_RESET_OUT  <= 1'b0;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  sequence s_reset_seen;
    bus_reset_s;
  endsequence
  sequence s_cleared;
    ##1 (DEV_ADDR_OUT == 7'h00 && !CONFIGURED_OUT);
  endsequence
  property p_busrst_clear;
    @(posedge CLK_IN) disable iff (RST_IN) s_reset_seen |-> s_cleared;
  endproperty
  a_busrst_clear: assert property (p_busrst_clear) else $error("address not cleared");
  property p_power_drop;
    @(posedge CLK_IN) disable iff (RST_IN)
      bus_reset_s |=> ((PORT_POWER_ENABLE_OUT & ~$past(CHARGE_PORT_ENABLE_IN)) == '0);
  endproperty
  a_power_drop: assert property (p_power_drop) else $error("uncharged port kept power");
  property p_flush;
    @(posedge CLK_IN) disable iff (RST_IN) bus_reset_s |=> TT_FLUSH_OUT;
  endproperty
  a_flush: assert property (p_flush) else $error("no flush on bus reset");
  property p_wake;
    @(posedge CLK_IN) disable iff (RST_IN) bus_reset_s |=> !SUSPENDED_OUT;
  endproperty
  a_wake: assert property (p_wake) else $error("still suspended");
  property p_no_forward;
    @(posedge CLK_IN) disable iff (RST_IN) !DS_RESET_OUT;
  endproperty
  a_no_forward: assert property (p_no_forward) else $error("reset forwarded");
  property p_smb_attach;
    @(posedge CLK_IN) disable iff (RST_IN)
      (state_q == HRS_SMB_LOAD && load_done_s) |-> ##[1:4] (state_q == HRS_ATTACHED);
  endproperty
  a_smb_attach: assert property (p_smb_attach) else $error("late attach");
  property p_ee_attach;
    @(posedge CLK_IN) disable iff (RST_IN)
      $rose(state_q == HRS_ATTACHED) |-> $past(state_q) == (mode_q ? HRS_SMB_WAIT : HRS_EE_WAIT);
  endproperty
  a_ee_attach: assert property (p_ee_attach) else $error("attach skipped wait");
  property p_smb_hold;
    @(posedge CLK_IN) disable iff (RST_IN)
      (state_q == HRS_SMB_LOAD && !load_done_s) |=> (state_q == HRS_SMB_LOAD);
  endproperty
  a_smb_hold: assert property (p_smb_hold) else $error("left load early");
  property p_oper;
    @(posedge CLK_IN) disable iff (RST_IN)
      (state_q != HRS_RECOVER) |=> OPERATIONAL_OUT;
  endproperty
  a_oper: assert property (p_oper) else $error("not operational");
endmodule : hrs_sequencer
`default_nettype wire

// File: core/hrs_timer.sv
// Purpose: Loadable down counter used for every sequencer delay
// Assumes: Load and run come from the same clock domain
// Notes:   Done is a registered level while count is zero and not loading
`include "hrs_map.svh"
`default_nettype none
module hrs_timer
  import hrs_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  load_in,
  input  wire logic [`HRS_CNT_W-1:0] value_in,
  output var  logic                  done_out
);
  logic [`HRS_CNT_W-1:0] cnt_q;   // Remaining cycles

  // ==========================================================
  // Counter
  // ==========================================================
  // Load takes priority; otherwise count down to zero and stop
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_q    <= '0;
      done_out <= 1'b0;
    end
    else if (load_in)
    begin
      cnt_q    <= value_in;
      done_out <= 1'b0;
    end
    else
    begin
      // Count down, flag when the last cycle passes
      if (cnt_q != '0)
        cnt_q <= cnt_q - `HRS_CNT_W'(1);
      done_out <= (cnt_q <= `HRS_CNT_W'(1));
    end
  end
endmodule : hrs_timer
`default_nettype wire

// File: tb/hrs_host_model.sv
// Purpose: Upstream host and code-load processor facing the sequencer
// Assumes: All host times scaled down to bench cycles
// Notes:   Drives code-load finish, bus reset and enumeration strobes
`include "hrs_map.svh"
`default_nettype none
module hrs_host_model
#(
  parameter int LOAD_CYC = 30, // Code-load time after recovery
  parameter int WAIT_CYC = 40, // Host wait after attach
  parameter int HOLD_CYC = 10  // Bus reset hold and recovery
)
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic smb_mode_in,        // Code-load mode strap
  input  wire logic operational_in,     // Hub recovery over
  input  wire logic attach_in,          // Hub attached upstream
  input  wire logic reset_req_in,       // Bench asks for another bus reset
  output var  logic load_done_out,      // Code load finished
  output var  logic bus_reset_out,      // Bus reset signalling
  output var  logic set_addr_valid_out, // Address strobe
  output var  logic set_config_out      // Configure strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] load_q; // Code-load cycles so far
  logic [15:0] cnt_q;  // Cycles in this phase
  logic [2:0]  ph_q;   // Idle, wait, reset, recover, address, config, done
  // ==========================================================
  // Code load
  // ==========================================================
  // In SMBus mode, load ends a fixed time after recovery and stays done
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      load_q <= 16'h0000;
    else if (operational_in && smb_mode_in && load_q != LOAD_CYC[15:0])
      load_q <= load_q + 16'h0001;
  assign load_done_out = (load_q == LOAD_CYC[15:0]);
  // ==========================================================
  // Host reset and enumeration
  // ==========================================================
  // Phases step on; the done phase reopens a reset on request
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      ph_q  <= 3'h0;
      cnt_q <= 16'h0000;
    end
    else
    begin
      cnt_q <= cnt_q + 16'h0001;
      if ((ph_q == 3'h0 && attach_in) ||
          (ph_q == 3'h1 && cnt_q >= WAIT_CYC[15:0]) ||
          (ph_q == 3'h2 && cnt_q >= HOLD_CYC[15:0] && !reset_req_in) ||
          (ph_q == 3'h3 && cnt_q >= HOLD_CYC[15:0]) ||
          ph_q == 3'h4 || ph_q == 3'h5)
      begin
        ph_q  <= ph_q + 3'h1;
        cnt_q <= 16'h0000;
      end
      else if (ph_q == 3'h6 && reset_req_in)
      begin
        ph_q  <= 3'h2;
        cnt_q <= 16'h0000;
      end
    end
  assign bus_reset_out      = (ph_q == 3'h2);
  assign set_addr_valid_out = (ph_q == 3'h4);
  assign set_config_out     = (ph_q == 3'h5);
endmodule // hrs_host_model
`default_nettype wire

// File: tb/hub_reset_attach_sequencer_test.sv
// Purpose: Self-checking bench for the hub reset and attach sequencer
// Assumes: Long waits shortened through the sequencer parameters
// Notes:   Table rows cover bus resets; boot paths are hand-written
`include "hrs_map.svh"
`default_nettype none
module hub_reset_attach_sequencer_test
  import hrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RC = 20; // Recovery cycles
  localparam int EE = 20; // Eeprom read cycles
  localparam int AT = 20; // Eeprom attach delay
  // One bus reset case
  typedef struct packed
  {
    logic [`HRS_ADDR_W-1:0] addr;
    logic [`HRS_NPORTS-1:0] chg;
    logic [`HRS_NPORTS-1:0] req;
    logic                   susp;
    logic [`HRS_NPORTS-1:0] kept; // Power left on through the bus reset
  } hrs_row_t;
  localparam hrs_row_t ROWS [4] = '{'{7'h2A, 4'h0, 4'hF, 1'b0, 4'h0}, '{7'h7F, 4'hF, 4'hF, 1'b1, 4'hF},
                                    '{7'h01, 4'h5, 4'h3, 1'b0, 4'h1}, '{7'h40, 4'hA, 4'hE, 1'b1, 4'hA}};
  logic                   CLK_IN, RST_IN, SMB_MODE_IN, LOAD_DONE_IN, BUS_RESET_IN, SUSPEND_REQ_IN;
  logic                   SET_CONFIG_IN, SET_ADDR_VALID_IN, OPERATIONAL_OUT, CFG_READ_OUT, ATTACH_OUT;
  logic                   CONFIGURED_OUT, TT_FLUSH_OUT, SUSPENDED_OUT, DS_RESET_OUT, reset_req;
  logic [`HRS_ADDR_W-1:0] SET_ADDR_IN, DEV_ADDR_OUT;
  logic [`HRS_NPORTS-1:0] PORT_ON_REQ_IN, CHARGE_PORT_ENABLE_IN, PORT_POWER_ENABLE_OUT;
  int                     n_fail = 0;
  int                     num_checks = 0;
`define CHK(nm, ex, got) \
  begin \
    num_checks++; \
    if ((got) !== (ex)) \
    begin \
      n_fail++; \
      $display("BAD %s expected %h seen %h", nm, ex, got); \
    end \
  end
  // ==========================================================
  // Design and host
  // ==========================================================
  hrs_sequencer #(.RECOVER_CYC(RC), .EEREAD_CYC(EE), .ATTACH_CYC(AT)) hrs_sequencer_i (.CLK_IN(CLK_IN),
    .RST_IN(RST_IN), .SMB_MODE_IN(SMB_MODE_IN), .LOAD_DONE_IN(LOAD_DONE_IN), .BUS_RESET_IN(BUS_RESET_IN),
    .SUSPEND_REQ_IN(SUSPEND_REQ_IN), .SET_CONFIG_IN(SET_CONFIG_IN), .SET_ADDR_IN(SET_ADDR_IN),
    .SET_ADDR_VALID_IN(SET_ADDR_VALID_IN), .PORT_ON_REQ_IN(PORT_ON_REQ_IN),
    .CHARGE_PORT_ENABLE_IN(CHARGE_PORT_ENABLE_IN), .OPERATIONAL_OUT(OPERATIONAL_OUT),
    .CFG_READ_OUT(CFG_READ_OUT), .ATTACH_OUT(ATTACH_OUT), .DEV_ADDR_OUT(DEV_ADDR_OUT),
    .CONFIGURED_OUT(CONFIGURED_OUT), .PORT_POWER_ENABLE_OUT(PORT_POWER_ENABLE_OUT),
    .TT_FLUSH_OUT(TT_FLUSH_OUT), .SUSPENDED_OUT(SUSPENDED_OUT), .DS_RESET_OUT(DS_RESET_OUT));
  hrs_host_model #(.LOAD_CYC(30), .WAIT_CYC(40), .HOLD_CYC(10)) hrs_host_model_i (.clk_in(CLK_IN),
    .rst_in(RST_IN), .smb_mode_in(SMB_MODE_IN), .operational_in(OPERATIONAL_OUT), .attach_in(ATTACH_OUT),
    .reset_req_in(reset_req), .load_done_out(LOAD_DONE_IN), .bus_reset_out(BUS_RESET_IN),
    .set_addr_valid_out(SET_ADDR_VALID_IN), .set_config_out(SET_CONFIG_IN));
  // ==========================================================
  // Clock, tasks and watchdog
  // ==========================================================
  always #2 CLK_IN = ~CLK_IN;
  // Step whole cycles, landing just after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_IN);
    #1;
  endtask
  // Wait for a level under a cycle limit
  task automatic wait_hi(ref logic s, input int lim, output int n);
    n = 0;
    while (s !== 1'b1 && n < lim)
    begin
      cyc(1);
      n++;
    end
  endtask
  // Hardware reset, then wait for recovery to end
  task automatic boot(input logic mode);
    int n;
    SMB_MODE_IN = mode;
    RST_IN      = 1'b1;
    cyc(5);
    `CHK("reset outputs", {7'h01, 7'h00, 4'h0}, {OPERATIONAL_OUT, CFG_READ_OUT, ATTACH_OUT, CONFIGURED_OUT, SUSPENDED_OUT, DS_RESET_OUT, TT_FLUSH_OUT, DEV_ADDR_OUT, PORT_POWER_ENABLE_OUT})
    RST_IN = 1'b0;
    wait_hi(OPERATIONAL_OUT, RC + 10, n);
    `CHK("recovery", 1'b1, OPERATIONAL_OUT && n >= RC - 1)
  endtask
  // Print the counts and the verdict, then end the run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Cut a hang short well beyond the expected run
  initial
  begin
    repeat (4000) @(posedge CLK_IN);
    n_fail++;
    stop_test();
  end
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    hrs_row_t r;
    int       n;
    CLK_IN                = 1'b0;
    RST_IN                = 1'b1;
    SMB_MODE_IN           = 1'b1;
    SUSPEND_REQ_IN        = 1'b0;
    SET_ADDR_IN           = 7'h11;
    PORT_ON_REQ_IN        = 4'h0;
    CHARGE_PORT_ENABLE_IN = 4'h0;
    reset_req             = 1'b0;
    boot(1'b1);
    wait_hi(LOAD_DONE_IN, 200, n);
    `CHK("early attach", 1'b0, ATTACH_OUT)
    wait_hi(ATTACH_OUT, 8, n);
    `CHK("smbus attach", 2'b10, {ATTACH_OUT, CFG_READ_OUT})
    wait_hi(CONFIGURED_OUT, 300, n);
    `CHK("enum address", {7'h11, 1'b1}, {DEV_ADDR_OUT, CONFIGURED_OUT})
    $display("test smbus boot done");
    foreach (ROWS[i])
    begin
      r                     = ROWS[i];
      SET_ADDR_IN           = r.addr;
      PORT_ON_REQ_IN        = r.req;
      CHARGE_PORT_ENABLE_IN = r.chg;
      SUSPEND_REQ_IN        = r.susp;
      cyc(6);
      `CHK("power on", r.req, PORT_POWER_ENABLE_OUT)
      `CHK("suspend", r.susp, SUSPENDED_OUT)
      reset_req = 1'b1;
      cyc(6);
      `CHK("bus reset state", {7'h00, 4'b0100}, {DEV_ADDR_OUT, CONFIGURED_OUT, TT_FLUSH_OUT, SUSPENDED_OUT, DS_RESET_OUT})
      `CHK("charge power", r.kept, PORT_POWER_ENABLE_OUT)
      reset_req      = 1'b0;
      SUSPEND_REQ_IN = 1'b0;
      wait_hi(CONFIGURED_OUT, 100, n);
      `CHK("new address", {r.addr, 2'b10}, {DEV_ADDR_OUT, CONFIGURED_OUT, TT_FLUSH_OUT})
      $display("test row %0d done", i);
    end
    boot(1'b0);
    cyc(3);
    `CHK("eeprom read", 1'b1, CFG_READ_OUT)
    wait_hi(ATTACH_OUT, EE + AT + 20, n);
    `CHK("eeprom attach", 1'b1, ATTACH_OUT && n >= EE + AT - 6)
    $display("test eeprom boot done");
    stop_test();
  end
endmodule // hub_reset_attach_sequencer_test
`default_nettype wire
